//--- pcm_timeslot_control.sv
// timeslot assignment, highway timing and word transfer of the voice codec
`timescale 1ns/10ps
module pcm_timeslot_control
    import pcm_ts_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              reset_i,
    input  wire logic              control_shift_clock_i,
    input  wire logic              control_serial_input_i,
    input  wire logic              tx_bit_clock_i,
    input  wire logic              rx_bit_clock_i,
    input  wire logic              tx_frame_sync_i,
    input  wire logic              rx_frame_sync_i,
    input  wire logic              rx_highway_in_i,
    output logic                   tx_highway_out_o,
    output logic                   tx_highway_oe_o,
    output logic                   tx_slot_indicator_oe_o,
    output logic                   power_down_o,
    input  wire logic [BUS_AW-1:0] bus_addr_i,
    input  wire logic [BUS_DW-1:0] bus_wdata_i,
    input  wire logic              bus_wr_i,
    input  wire logic              bus_rd_i,
    output logic [BUS_DW-1:0]      bus_rdata_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and counters
    logic             cclk_level;
    logic             cclk_fall;
    logic             dc_level;
    logic             txc_rise;
    logic             rxc_rise;
    logic             rxc_fall;
    logic             txfs_level;
    logic             rxfs_level;
    logic             din_level;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W-1:0] rx_cnt;
    logic             tx_tick;
    logic             tx_start;

    edge_sync u_sync_cclk (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(control_shift_clock_i),
        .level_o(cclk_level), .rise_o(), .fall_o(cclk_fall));
    edge_sync u_sync_dc (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(control_serial_input_i),
        .level_o(dc_level), .rise_o(), .fall_o());
    edge_sync u_sync_txc (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(tx_bit_clock_i),
        .level_o(), .rise_o(txc_rise), .fall_o());
    edge_sync u_sync_rxc (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(rx_bit_clock_i),
        .level_o(), .rise_o(rxc_rise), .fall_o(rxc_fall));
    edge_sync u_sync_txfs (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(tx_frame_sync_i),
        .level_o(txfs_level), .rise_o(), .fall_o());
    edge_sync u_sync_rxfs (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(rx_frame_sync_i),
        .level_o(rxfs_level), .rise_o(), .fall_o());
    edge_sync u_sync_din (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(rx_highway_in_i),
        .level_o(din_level), .rise_o(), .fall_o());

    slot_counter #(.W(CNT_W)) u_tx_cnt (.mclk_i(mclk_i), .reset_i(reset_i),
        .bit_rise_i(txc_rise), .frame_sync_i(txfs_level), .cnt_o(tx_cnt),
        .tick_o(tx_tick), .frame_start_o(tx_start));
    slot_counter #(.W(CNT_W)) u_rx_cnt (.mclk_i(mclk_i), .reset_i(reset_i),
        .bit_rise_i(rxc_rise), .frame_sync_i(rxfs_level), .cnt_o(rx_cnt),
        .tick_o(), .frame_start_o());

    ////////////////////////////////////////////////////////////////////////////////
    // serial control word and direct mode
    logic [WORD_W-1:0] ctrl_shift_reg;
    logic [WORD_W-1:0] ctrl_shift_next;
    logic [2:0]        ctrl_bits_reg;
    logic [2:0]        ctrl_bits_next;
    logic              ctrl_done_reg;
    logic              ctrl_done_next;
    logic              direct_reg;
    logic              direct_next;
    logic [1:0]        dir_frames_reg;
    logic [1:0]        dir_frames_next;
    logic              sel_applied_reg;
    logic              sel_applied_next;
    logic [1:0]        sel_frames_reg;
    logic [1:0]        sel_frames_next;
    logic              dir_apply_reg;
    logic              dir_apply_next;

    always_comb begin
        ctrl_shift_next  = ctrl_shift_reg;
        ctrl_bits_next   = ctrl_bits_reg;
        ctrl_done_next   = 1'b0;
        direct_next      = direct_reg;
        dir_frames_next  = dir_frames_reg;
        sel_applied_next = sel_applied_reg;
        sel_frames_next  = sel_frames_reg;
        dir_apply_next   = 1'b0;
        if (cclk_fall && !direct_reg) begin
            ctrl_shift_next = {ctrl_shift_reg[WORD_W-2:0], dc_level};
            ctrl_bits_next  = ctrl_bits_reg + 3'h1;
            ctrl_done_next  = (ctrl_bits_reg == 3'h7);
        end
        if (!cclk_level) begin
            direct_next     = 1'b0;
            dir_frames_next = 2'h0;
        end else if (!direct_reg) begin
            if (tx_start) begin
                if (dir_frames_reg == 2'(DIRECT_ENTRY_FRAMES - 1)) begin
                    direct_next      = 1'b1;
                    dir_apply_next   = 1'b1;
                    sel_applied_next = dc_level;
                    ctrl_bits_next   = 3'h0;
                end else begin
                    dir_frames_next = dir_frames_reg + 2'h1;
                end
            end
        end else if (dc_level == sel_applied_reg) begin
            sel_frames_next = 2'h0;
        end else if (tx_start) begin
            if (sel_frames_reg == 2'(DIRECT_CHANGE_FRAMES - 1)) begin
                dir_apply_next   = 1'b1;
                sel_applied_next = dc_level;
                sel_frames_next  = 2'h0;
            end else begin
                sel_frames_next = sel_frames_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctrl_shift_reg  <= '0;
            ctrl_bits_reg   <= 3'h0;
            ctrl_done_reg   <= 1'b0;
            direct_reg      <= 1'b0;
            dir_frames_reg  <= 2'h0;
            sel_applied_reg <= 1'b1;
            sel_frames_reg  <= 2'h0;
            dir_apply_reg   <= 1'b0;
        end else begin
            ctrl_shift_reg  <= ctrl_shift_next;
            ctrl_bits_reg   <= ctrl_bits_next;
            ctrl_done_reg   <= ctrl_done_next;
            direct_reg      <= direct_next;
            dir_frames_reg  <= dir_frames_next;
            sel_applied_reg <= sel_applied_next;
            sel_frames_reg  <= sel_frames_next;
            dir_apply_reg   <= dir_apply_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assignment state
    assign_s asg_reg;
    assign_s asg_next;
    logic    pd_reg;
    logic    pd_next;

    always_comb begin
        asg_next = asg_reg;
        if (ctrl_done_reg) begin
            asg_next.standby = 1'b0;
            case (ctrl_shift_reg[7:6])
                CMD_BOTH: begin
                    asg_next.tx_asg  = 1'b1;
                    asg_next.rx_asg  = 1'b1;
                    asg_next.tx_slot = ctrl_shift_reg[5:0];
                    asg_next.rx_slot = ctrl_shift_reg[5:0];
                end
                CMD_TX: begin
                    asg_next.tx_asg  = 1'b1;
                    asg_next.tx_slot = ctrl_shift_reg[5:0];
                end
                CMD_RX: begin
                    asg_next.rx_asg  = 1'b1;
                    asg_next.rx_slot = ctrl_shift_reg[5:0];
                    if (!asg_reg.tx_asg) begin
                        asg_next.tx_asg  = 1'b1;
                        asg_next.tx_slot = SLOT_FIRST;
                    end
                end
                default: asg_next.standby = 1'b1;
            endcase
        end else if (dir_apply_reg) begin
            if (sel_applied_reg) begin
                asg_next.standby = 1'b1;
            end else begin
                asg_next = '{standby: 1'b0, tx_asg: 1'b1, rx_asg: 1'b1,
                             tx_slot: SLOT_FIRST, rx_slot: SLOT_FIRST};
            end
        end
        pd_next = asg_reg.standby | ~(asg_reg.tx_asg | asg_reg.rx_asg);
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            asg_reg <= ASSIGN_RESET;
            pd_reg  <= 1'b1;
        end else begin
            asg_reg <= asg_next;
            pd_reg  <= pd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transmit highway
    logic              tx_live;
    logic              tx_match;
    logic [2:0]        tx_bit;
    logic [WORD_W-1:0] tx_word_sel;
    logic [WORD_W-1:0] tx_data_reg;
    logic [WORD_W-1:0] tx_data_next;
    logic [WORD_W-1:0] tx_sample_reg;
    logic [WORD_W-1:0] tx_sample_next;
    logic [WORD_W-1:0] tx_shift_reg;
    logic [WORD_W-1:0] tx_shift_next;
    logic              tx_out_reg;
    logic              tx_out_next;
    logic              tx_oe_reg;
    logic              tx_oe_next;

    always_comb begin
        tx_live        = !asg_reg.standby && asg_reg.tx_asg;
        tx_match       = !tx_cnt[CNT_W-1] && tx_cnt[8:3] == asg_reg.tx_slot;
        tx_bit         = tx_cnt[2:0];
        tx_word_sel    = (tx_bit == 3'h0) ? tx_sample_reg : tx_shift_reg;
        tx_data_next   = (bus_wr_i && bus_addr_i == ADDR_TX_WORD) ?
                         bus_wdata_i[WORD_W-1:0] : tx_data_reg;
        tx_sample_next = tx_sample_reg;
        tx_shift_next  = tx_shift_reg;
        tx_out_next    = tx_out_reg;
        tx_oe_next     = tx_oe_reg;
        if (!tx_live) begin
            tx_out_next = 1'b0;
            tx_oe_next  = 1'b0;
        end else if (tx_tick) begin
            tx_oe_next = tx_match && (tx_bit == 3'h0 || tx_oe_reg);
            if (tx_oe_next) begin
                if (tx_bit == 3'h0) begin
                    tx_shift_next  = tx_sample_reg;
                    tx_sample_next = tx_data_reg;
                end
                tx_out_next = tx_word_sel[3'h7 - tx_bit];
            end else begin
                tx_out_next = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            tx_data_reg   <= TX_WORD_RESET;
            tx_sample_reg <= TX_WORD_RESET;
            tx_shift_reg  <= TX_WORD_RESET;
            tx_out_reg    <= 1'b0;
            tx_oe_reg     <= 1'b0;
        end else begin
            tx_data_reg   <= tx_data_next;
            tx_sample_reg <= tx_sample_next;
            tx_shift_reg  <= tx_shift_next;
            tx_out_reg    <= tx_out_next;
            tx_oe_reg     <= tx_oe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive highway and register bus
    logic              rx_live;
    logic              rx_match;
    logic              rx_end;
    logic [WORD_W-1:0] rx_shift_reg;
    logic [WORD_W-1:0] rx_shift_next;
    logic [WORD_W-1:0] rx_word_reg;
    logic [WORD_W-1:0] rx_word_next;
    logic              rx_new_reg;
    logic              rx_new_next;
    logic [BUS_DW-1:0] rdata_reg;
    logic [BUS_DW-1:0] rdata_next;

    always_comb begin
        rx_live       = !asg_reg.standby && asg_reg.rx_asg;
        rx_match      = !rx_cnt[CNT_W-1] && rx_cnt[8:3] == asg_reg.rx_slot;
        rx_end        = rx_live && rxc_fall && rx_match && rx_cnt[2:0] == 3'h7;
        rx_shift_next = rx_shift_reg;
        rx_word_next  = rx_word_reg;
        rx_new_next   = rx_new_reg;
        if (bus_rd_i && bus_addr_i == ADDR_RX_WORD) begin
            rx_new_next = 1'b0;
        end
        if (rx_live && rxc_fall && rx_match) begin
            rx_shift_next = {rx_shift_reg[WORD_W-2:0], din_level};
        end
        if (rx_end) begin
            rx_word_next = {rx_shift_reg[WORD_W-2:0], din_level};
            rx_new_next  = 1'b1;
        end
        rdata_next = '0;
        if (bus_rd_i) begin
            case (bus_addr_i)
                ADDR_TX_WORD: rdata_next = {{(BUS_DW-WORD_W){1'b0}}, tx_data_reg};
                ADDR_RX_WORD: rdata_next = {{(BUS_DW-WORD_W-1){1'b0}}, rx_new_reg, rx_word_reg};
                ADDR_STATUS:  rdata_next = {11'h000, direct_reg, pd_reg, asg_reg.standby,
                                            asg_reg.rx_asg, asg_reg.tx_asg, 2'h0,
                                            asg_reg.rx_slot, 2'h0, asg_reg.tx_slot};
                default:      rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rx_shift_reg <= '0;
            rx_word_reg  <= '0;
            rx_new_reg   <= 1'b0;
            rdata_reg    <= '0;
        end else begin
            rx_shift_reg <= rx_shift_next;
            rx_word_reg  <= rx_word_next;
            rx_new_reg   <= rx_new_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign tx_highway_out_o       = tx_out_reg;
    assign tx_highway_oe_o        = tx_oe_reg;
    assign tx_slot_indicator_oe_o = tx_oe_reg;
    assign power_down_o           = pd_reg;
    assign bus_rdata_o            = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence s_word_done(logic [1:0] cmd);
        ctrl_done_reg && ctrl_shift_reg[7:6] == cmd;
    endsequence

    a_tx_cmd_load: assert property (
        s_word_done(CMD_TX) |=> asg_reg.tx_asg && !asg_reg.standby
            && asg_reg.tx_slot == $past(ctrl_shift_reg[5:0]))
        else $error("transmit command did not load the slot");

    a_standby_cmd: assert property (
        s_word_done(CMD_STANDBY) |=> asg_reg.standby ##1 power_down_o ##1 !tx_highway_oe_o)
        else $error("standby command did not power down");

    a_rx_first_tx: assert property (
        s_word_done(CMD_RX) && !asg_reg.tx_asg |=> asg_reg.tx_asg
            && asg_reg.tx_slot == SLOT_FIRST)
        else $error("receive-first command left transmit unassigned");

    a_assign_hold: assert property (
        !ctrl_done_reg && !dir_apply_reg |=> asg_reg == $past(asg_reg))
        else $error("assignment changed without a command");

    a_idle_hiz: assert property (
        !tx_live |=> !tx_highway_oe_o && !tx_slot_indicator_oe_o)
        else $error("transmit output driven while not live");

    a_slot_start: assert property (
        $rose(tx_highway_oe_o) |-> $past(tx_bit) == 3'h0
            && $past(tx_cnt[8:3]) == asg_reg.tx_slot && $past(tx_tick))
        else $error("transmit slot opened at the wrong bit");

    a_slot_shift: assert property (
        tx_live && tx_tick && tx_match && tx_bit == 3'h0
            |=> tx_shift_reg == $past(tx_sample_reg) && tx_highway_out_o == tx_shift_reg[7])
        else $error("transmit word not taken from the previous frame");

    a_rx_capture: assert property (
        $changed(rx_word_reg) |-> $past(rx_end))
        else $error("receive word changed outside its slot");

    a_direct_sel: assert property (
        dir_apply_reg && !sel_applied_reg |=> !asg_reg.standby && asg_reg.tx_asg
            && asg_reg.tx_slot == SLOT_FIRST && asg_reg.rx_slot == SLOT_FIRST)
        else $error("direct select did not assign the first slots");
endmodule

//--- pcm_ts_pkg.sv
// constants, command codes and carrier types for the pcm timeslot control block
// Functional notes
// - first two bits pick target or standby
// - six slot bits, msb first, code+1
// - control bits taken on control clock fall
// - slot indicator low only while word shifts
// - assignments held until replaced
// - own tx/rx counters, cleared each frame
// - any slot pair accepted, even equal
// - power-on: no direction assigned
// - receive-first assignment gives tx slot 1
// - 01000001,10000010 give tx 2, rx 3
// - control clock high selects direct mode
// - direct mode within three frames
// - both directions power down together
// - tx word sent in next frame's slot
// - rx word captured in slot, held
package pcm_ts_pkg;
    localparam int WORD_W             = 8;
    localparam int SLOT_W             = 6;
    localparam int CNT_W              = 10;
    localparam int BUS_AW             = 8;
    localparam int BUS_DW             = 32;
    localparam int DIRECT_ENTRY_FRAMES = 2;
    localparam int DIRECT_CHANGE_FRAMES = 2;
    localparam logic [1:0] CMD_BOTH    = 2'h0;
    localparam logic [1:0] CMD_TX      = 2'h1;
    localparam logic [1:0] CMD_RX      = 2'h2;
    localparam logic [1:0] CMD_STANDBY = 2'h3;
    localparam logic [BUS_AW-1:0] ADDR_TX_WORD = 8'h00;
    localparam logic [BUS_AW-1:0] ADDR_RX_WORD = 8'h04;
    localparam logic [BUS_AW-1:0] ADDR_STATUS  = 8'h08;
    localparam logic [WORD_W-1:0] TX_WORD_RESET = 8'hFF;
    localparam logic [SLOT_W-1:0] SLOT_FIRST    = 6'h00;

    typedef struct packed {
        logic              standby;
        logic              tx_asg;
        logic              rx_asg;
        logic [SLOT_W-1:0] tx_slot;
        logic [SLOT_W-1:0] rx_slot;
    } assign_s;

    localparam assign_s ASSIGN_RESET = '{standby: 1'b0, tx_asg: 1'b0, rx_asg: 1'b0,
                                         tx_slot: 6'h00, rx_slot: 6'h00};
endpackage

//--- edge_sync.sv
// two-stage synchroniser with rise and fall detection on the second stage
`timescale 1ns/10ps
module edge_sync
    import pcm_ts_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic reset_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic stage1_reg;
    logic stage2_reg;
    logic prev_reg;
    logic stage1_next;
    logic stage2_next;
    logic prev_next;

    always_comb begin
        stage1_next = async_i;
        stage2_next = stage1_reg;
        prev_next   = stage2_reg;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            prev_reg   <= 1'b0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
            prev_reg   <= prev_next;
        end
    end

    assign level_o = stage2_reg;
    assign rise_o  = stage2_reg & ~prev_reg;
    assign fall_o  = ~stage2_reg & prev_reg;
endmodule

//--- slot_counter.sv
// bit counter of one highway direction, cleared by the start of its frame sync
`timescale 1ns/10ps
module slot_counter
    import pcm_ts_pkg::*;
#(
    parameter int W = CNT_W
)
(
    input  wire logic         mclk_i,
    input  wire logic         reset_i,
    input  wire logic         bit_rise_i,
    input  wire logic         frame_sync_i,
    output logic [W-1:0]      cnt_o,
    output logic              tick_o,
    output logic              frame_start_o
);
    localparam logic [W-1:0] CNT_MAX = '1;

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         fs_prev_reg;
    logic         fs_prev_next;
    logic         tick_reg;
    logic         tick_next;
    logic         start_reg;
    logic         start_next;

    always_comb begin
        cnt_next     = cnt_reg;
        fs_prev_next = fs_prev_reg;
        tick_next    = bit_rise_i;
        start_next   = 1'b0;
        if (bit_rise_i) begin
            fs_prev_next = frame_sync_i;
            if (frame_sync_i && !fs_prev_reg) begin
                cnt_next   = '0;
                start_next = 1'b1;
            end else if (cnt_reg != CNT_MAX) begin
                cnt_next = cnt_reg + W'(1);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cnt_reg     <= CNT_MAX;
            fs_prev_reg <= 1'b0;
            tick_reg    <= 1'b0;
            start_reg   <= 1'b0;
        end else begin
            cnt_reg     <= cnt_next;
            fs_prev_reg <= fs_prev_next;
            tick_reg    <= tick_next;
            start_reg   <= start_next;
        end
    end

    assign cnt_o         = cnt_reg;
    assign tick_o        = tick_reg;
    assign frame_start_o = start_reg;

    a_count_clear: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        bit_rise_i && frame_sync_i && !fs_prev_reg |=> frame_start_o && cnt_o == '0)
        else $error("frame sync did not clear the bit counter");

    a_count_step: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        bit_rise_i && !(frame_sync_i && !fs_prev_reg) && cnt_reg != CNT_MAX
        |=> cnt_o == $past(cnt_o) + W'(1))
        else $error("bit counter did not advance on a bit clock");
endmodule

//--- highway_source.sv
// highway timing source: shared bit clock, frame sync and receive data
`timescale 1ns/10ps
module highway_source #(
    parameter int         FRAME_BITS = 64,
    parameter logic [7:0] RX_BYTE    = 8'h5A,
    parameter int         RX_FIRST   = 16
)
(
    output logic       bit_clk_o,
    output logic       frame_sync_o,
    output logic       rx_data_o,
    output logic [6:0] bit_idx_o
);
    initial begin
        bit_clk_o = 1'b0;
        frame_sync_o = 1'b0;
        rx_data_o = 1'b0;
        bit_idx_o = 7'h00;
        #3;
        forever #80 bit_clk_o = ~bit_clk_o;
    end
    ////////////////////////////////////////////////////////////////////////
    // sync high across the rise of bit 0, every frame
    always @(negedge bit_clk_o) begin
        bit_idx_o <= (bit_idx_o == 7'(FRAME_BITS - 1)) ? 7'h00 : bit_idx_o + 7'h01;
        frame_sync_o <= (bit_idx_o == 7'(FRAME_BITS - 1));
    end
    // slot byte msb first, toggling pattern elsewhere
    always @(posedge bit_clk_o) begin
        if (bit_idx_o >= 7'(RX_FIRST) && bit_idx_o < 7'(RX_FIRST + 8)) begin
            rx_data_o <= RX_BYTE[~bit_idx_o[2:0]];
        end else begin
            rx_data_o <= ~rx_data_o;
        end
    end
endmodule

//--- pcm_timeslot_control_test.sv
// self-checking bench of the timeslot control block
`timescale 1ns/10ps
module pcm_timeslot_control_test;
    import pcm_ts_pkg::*;
    logic              mclk, reset, ctl_clk, ctl_dat, wr, rd;
    logic              bclk, fsync, rx_dat, tx_out, tx_oe, ind_oe, pdn;
    logic [6:0]        bidx;
    logic [7:0]        cap;
    logic [BUS_AW-1:0] addr;
    logic [BUS_DW-1:0] wdata, rdata, rv;
    int                miscompares, n_tests, cycles, nbits, first_idx;

    highway_source highway_source_i (.bit_clk_o(bclk), .frame_sync_o(fsync),
        .rx_data_o(rx_dat), .bit_idx_o(bidx));
    pcm_timeslot_control pcm_timeslot_control_i (.mclk_i(mclk), .reset_i(reset),
        .control_shift_clock_i(ctl_clk), .control_serial_input_i(ctl_dat),
        .tx_bit_clock_i(bclk), .rx_bit_clock_i(bclk), .tx_frame_sync_i(fsync),
        .rx_frame_sync_i(fsync), .rx_highway_in_i(rx_dat), .tx_highway_out_o(tx_out),
        .tx_highway_oe_o(tx_oe), .tx_slot_indicator_oe_o(ind_oe), .power_down_o(pdn),
        .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd),
        .bus_rdata_o(rdata));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic bus_write(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic bus_read(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check("read data", e, rdata);
    endtask
    task automatic send_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk);
            ctl_dat <= w[i];
            ctl_clk <= 1'b1;
            repeat (6) @(posedge mclk);
            ctl_clk <= 1'b0;
            repeat (6) @(posedge mclk);
        end
        repeat (3840) @(posedge mclk);
    endtask
    task automatic capture(input string what, input logic [7:0] w, input int idx, input int n);
        nbits = 0;
        first_idx = 0;
        cap = 8'h00;
        @(posedge fsync);
        check(what, {8'h00, 8'(idx), 8'(n), w}, {8'h00, 8'(first_idx), 8'(nbits), cap});
        $display("done %s", what);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // shift in what the block drives during each bit
    always @(negedge bclk) begin
        check("indicator", {31'h0, tx_oe}, {31'h0, ind_oe});
        if (tx_oe !== 1'b1) begin
            check("idle data", 32'h0, {31'h0, tx_out});
        end
        if (ind_oe === 1'b1) begin
            if (nbits == 0) first_idx = bidx;
            cap = {cap[6:0], tx_out};
            nbits++;
        end
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 70000) begin
            miscompares++;
            give_verdict;
        end
    end
    initial begin
        {reset, ctl_clk, ctl_dat, wr, rd} = 5'h10;
        addr = '0;
        wdata = '0;
        {miscompares, n_tests, cycles, nbits, first_idx} = '0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        bus_read(ADDR_STATUS, 32'h0008_0000);
        send_word({CMD_STANDBY, 6'h00});
        bus_read(ADDR_STATUS, 32'h000C_0000);
        send_word({CMD_RX, 6'h02});
        bus_read(ADDR_STATUS, 32'h0003_0200);
        bus_write(ADDR_TX_WORD, 32'h0000_00A5);
        send_word({CMD_TX, 6'h01});
        bus_read(ADDR_STATUS, 32'h0003_0201);
        @(posedge fsync);
        capture("tx slot two", 8'hA5, 8, 8);
        bus_write(ADDR_TX_WORD, 32'h0000_003C);
        capture("previous word", 8'hA5, 8, 8);
        capture("new word", 8'h3C, 8, 8);
        bus_read(ADDR_RX_WORD, 32'h0000_015A);
        bus_read(ADDR_RX_WORD, 32'h0000_005A);
        send_word({CMD_BOTH, 6'h02});
        bus_read(ADDR_STATUS, 32'h0003_0202);
        @(posedge fsync);
        capture("shared slot", 8'h3C, 16, 8);
        send_word({CMD_STANDBY, 6'h15});
        bus_read(ADDR_STATUS, 32'h000F_0202);
        @(posedge fsync);
        capture("standby", 8'h00, 0, 0);
        bus_read(8'h0C, 32'h0000_0000);
        send_word({CMD_TX, 6'h3F});
        @(posedge fsync);
        capture("dummy slot", 8'h00, 0, 0);
        send_word({CMD_TX, 6'h01});
        send_word({CMD_RX, 6'h02});
        bus_read(ADDR_STATUS, 32'h0003_0201);
        ctl_dat <= 1'b0;
        ctl_clk <= 1'b1;
        repeat (3840) @(posedge mclk);
        bus_read(ADDR_STATUS, 32'h0013_0000);
        @(posedge fsync);
        capture("direct slot", 8'h3C, 0, 8);
        ctl_dat <= 1'b1;
        repeat (3840) @(posedge mclk);
        check("direct power down", 32'h1, {31'h0, pdn});
        give_verdict;
    end
endmodule
